// *** design/scm_pkg.sv ***
package scm_pkg;

	// ------------------------------------------------------------
	// Register map, byte addresses of aligned 32-bit words.
	// ------------------------------------------------------------
	localparam logic [7:0] SCM_OFF_MODE   = 8'h00;
	localparam logic [7:0] SCM_OFF_CTRL   = 8'h04;
	localparam logic [7:0] SCM_OFF_DATA   = 8'h08;
	localparam logic [7:0] SCM_OFF_STATUS = 8'h0C;

	// ------------------------------------------------------------
	// Field positions in the channel mode register.
	// ------------------------------------------------------------
	localparam int SCM_MODE_RXE_BIT  = 0;
	localparam int SCM_MODE_SEL_LSB  = 1;
	localparam int SCM_MODE_WAKE_BIT = 3;
	localparam int SCM_MODE_TX9_BIT  = 4;
	localparam int SCM_MODE_EXT_BIT  = 5;

	// ------------------------------------------------------------
	// Field positions in the channel control and status registers.
	// ------------------------------------------------------------
	localparam int SCM_CTRL_RX9_BIT  = 0;
	localparam int SCM_CTRL_PE_BIT   = 1;
	localparam int SCM_CTRL_EVEN_BIT = 2;
	localparam int SCM_CTRL_PARITY_ERROR_FLAG_BIT = 3;
	localparam int SCM_CTRL_FRAMING_ERROR_FLAG_BIT = 4;
	localparam int SCM_CTRL_OVERRUN_ERROR_FLAG_BIT = 5;
	localparam int SCM_STAT_PEND_BIT = 0;
	localparam int SCM_STAT_BUSY_BIT = 1;

	// ------------------------------------------------------------
	// Values after reset.
	// ------------------------------------------------------------
	localparam logic [5:0] SCM_MODE_RST = 6'h00;
	localparam logic [2:0] SCM_CTRL_RST = 3'h0;
	localparam logic [7:0] SCM_BUF_RST  = 8'h00;

	// ------------------------------------------------------------
	// Oversampling counts of the asynchronous receiver and transmitter, and the shift-mode word length.
	// ------------------------------------------------------------
	localparam logic [3:0] SCM_TICK_LAST  = 4'hF;
	localparam logic [3:0] SCM_SAMPLE_A   = 4'h7;
	localparam logic [3:0] SCM_SAMPLE_B   = 4'h8;
	localparam logic [3:0] SCM_SAMPLE_C   = 4'h9;
	localparam logic [3:0] SCM_SHIFT_BITS = 4'h8;

	typedef enum logic [1:0] {
		SCM_MODE_SHIFT = 2'b00,
		SCM_MODE_7BIT  = 2'b01,
		SCM_MODE_8BIT  = 2'b10,
		SCM_MODE_9BIT  = 2'b11
	} scm_mode_t;

	typedef enum logic [1:0] {
		SCM_RX_IDLE  = 2'b00,
		SCM_RX_START = 2'b01,
		SCM_RX_BITS  = 2'b10,
		SCM_RX_STOP  = 2'b11
	} scm_rx_state_t;

endpackage

// *** design/scm_tx.sv ***
`timescale 1ns/1ps
`default_nettype none

module scm_tx
(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       baud_tick,
	input  wire logic       load,
	input  wire logic [8:0] payload,
	input  wire logic [3:0] nbits,
	output logic            busy,
	output logic            txd
);
	import scm_pkg::*;

	logic [8:0] shift_q;
	logic [3:0] tick_q;
	logic [3:0] left_q;
	logic       busy_q;
	logic       txd_q;

	// ------------------------------------------------------------
	// Frame serialiser.
	// ------------------------------------------------------------

	// The start bit goes out at once on load; payload bits follow LSB first, and ones shifted in
	// from the top form the stop bit, so the line rests high between frames.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_q <= 9'h1FF;
			tick_q  <= 4'h0;
			left_q  <= 4'h0;
			busy_q  <= 1'b0;
			txd_q   <= 1'b1;
		end
		else if (load && !busy_q)
		begin
			shift_q <= payload;
			tick_q  <= 4'h0;
			left_q  <= nbits + 4'h1;
			busy_q  <= 1'b1;
			txd_q   <= 1'b0;
		end
		else if (busy_q && baud_tick)
		begin
			tick_q <= tick_q + 4'h1;
			if (tick_q == SCM_TICK_LAST)
			begin
				if (left_q == 4'h0)
				begin
					busy_q <= 1'b0;
					txd_q  <= 1'b1;
				end
				else
				begin
					txd_q   <= shift_q[0];
					shift_q <= {1'b1, shift_q[8:1]};
					left_q  <= left_q - 4'h1;
				end
			end
		end
	end

	assign busy = busy_q;
	assign txd  = txd_q;

endmodule
`default_nettype wire

// *** design/scm_serial_channel.sv ***
// What this block does
// - Internal shift clock receives only when not pending
// - Eight shifted bits load buffer, pending, interrupt
// - External shift clock edge shifts when not pending
// - Receive only while receive enable is set
// - Mode 01 is seven-bit asynchronous, optional parity
// - Mode 10 is eight-bit asynchronous, optional parity
// - Mode 11 is nine-bit, never any parity
// - Parity only when enabled; polarity picks even/odd
// - Ninth bit sent from mode, stored in control
// - Wake filter drops frames whose ninth bit clear
// - Stop bit majority of three; low sets framing
// - New word while buffer full sets overrun
// - Received parity mismatch sets parity error
// - Transmit shifts out least significant bit first
`timescale 1ns/1ps
`default_nettype none

module scm_serial_channel
#(
	parameter int SHIFT_HALF = 8
)
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        baud_tick,
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin,
	input  wire logic        shift_clock_pin_in,
	output logic             shift_clock_pin_out,
	output logic             shift_clock_pin_oe,
	output logic             rx_interrupt
);
	import scm_pkg::*;

	// ------------------------------------------------------------
	// Declarations.
	// ------------------------------------------------------------
	logic [5:0]    channel_mode_reg_q;
	logic [2:0]    ctrl_cfg_q;
	logic          parity_error_flag_q;
	logic          framing_error_flag_q;
	logic          overrun_error_flag_q;
	logic          rx_ninth_bit_q;
	logic [7:0]    rx_buf_q;
	logic          rx_pending_flag_q;
	logic          rx_irq_q;
	logic          pready_q;
	logic          pslverr_q;
	logic [31:0]   prdata_q;
	logic [1:0]    rx_sync_q;
	logic [1:0]    sclk_sync_q;
	logic          sclk_prev_q;
	scm_rx_state_t rx_state_q;
	logic [3:0]    rx_tick_q;
	logic [3:0]    rx_idx_q;
	logic [1:0]    rx_samp_q;
	logic [8:0]    rx_bits_q;
	logic          sh_active_q;
	logic [15:0]   sh_half_q;
	logic          sclk_out_q;
	logic [3:0]    sh_cnt_q;
	logic [7:0]    sh_bits_q;
	logic          sh_done_q;
	logic          tx_busy;
	logic          tx_load;
	logic [8:0]    tx_payload;
	logic [3:0]    tx_nbits;
	logic          rx_enable;
	scm_mode_t     mode_sel;
	logic          wake_filter_bit;
	logic          tx_ninth_bit;
	logic          ext_clock;
	logic          parity_enable_bit;
	logic          parity_even;
	logic          parity_on;
	logic [3:0]    frame_bits;
	logic          rx_in;
	logic          maj;
	logic          bus_done;
	logic          wr_done;
	logic          rd_data_done;
	logic          mapped;
	logic          async_done;
	logic          rx_wake_drop;
	logic          rx_accept;
	logic          rx_overrun;
	logic          rx_par_bad;
	logic          sclk_rise;
	logic          sh_sample;
	logic [31:0]   rd_value;

	// Majority of three samples taken around the bit centre.
	function automatic logic maj3(input logic a, input logic b, input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction

	// ------------------------------------------------------------
	// Decoded configuration.
	// ------------------------------------------------------------

	// Parity is suppressed in nine-bit mode whatever the enable says.
	assign rx_enable         = channel_mode_reg_q[SCM_MODE_RXE_BIT];
	assign mode_sel          = scm_mode_t'(channel_mode_reg_q[SCM_MODE_SEL_LSB +: 2]);
	assign wake_filter_bit   = channel_mode_reg_q[SCM_MODE_WAKE_BIT];
	assign tx_ninth_bit      = channel_mode_reg_q[SCM_MODE_TX9_BIT];
	assign ext_clock         = channel_mode_reg_q[SCM_MODE_EXT_BIT];
	assign parity_enable_bit = ctrl_cfg_q[0];
	assign parity_even       = ctrl_cfg_q[1];
	assign parity_on         = parity_enable_bit && (mode_sel != SCM_MODE_9BIT);

	// Bits after the start bit and before the stop bit.
	always_comb
	begin
		unique case (mode_sel)
			SCM_MODE_7BIT:  frame_bits = parity_on ? 4'h8 : 4'h7;
			SCM_MODE_8BIT:  frame_bits = parity_on ? 4'h9 : 4'h8;
			SCM_MODE_9BIT:  frame_bits = 4'h9;
			SCM_MODE_SHIFT: frame_bits = SCM_SHIFT_BITS;
		endcase
	end

	// ------------------------------------------------------------
	// Pin synchronisers.
	// ------------------------------------------------------------

	// Both pins come from outside the clock domain; only the second stage is ever read.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_sync_q   <= 2'h3;
			sclk_sync_q <= 2'h3;
			sclk_prev_q <= 1'b1;
		end
		else
		begin
			rx_sync_q   <= {rx_sync_q[0], serial_in_pin};
			sclk_sync_q <= {sclk_sync_q[0], shift_clock_pin_in};
			sclk_prev_q <= sclk_sync_q[1];
		end
	end

	assign rx_in     = rx_sync_q[1];
	assign sclk_rise = sclk_sync_q[1] && !sclk_prev_q;

	// ------------------------------------------------------------
	// APB slave.
	// ------------------------------------------------------------

	// One wait state: pready rises in the second access cycle, so every answer comes from a flop.
	assign bus_done     = psel && penable && pready_q;
	assign wr_done      = bus_done && pwrite && mapped;
	assign rd_data_done = bus_done && !pwrite && (paddr == SCM_OFF_DATA);
	assign mapped       = (paddr == SCM_OFF_MODE) || (paddr == SCM_OFF_CTRL) ||
	                      (paddr == SCM_OFF_DATA) || (paddr == SCM_OFF_STATUS);

	// Read multiplexer; reserved bits and unmapped addresses read as zero.
	always_comb
	begin
		rd_value = 32'h0000_0000;
		unique case (paddr)
			SCM_OFF_MODE:   rd_value[5:0] = channel_mode_reg_q;
			SCM_OFF_CTRL:   rd_value[5:0] = {overrun_error_flag_q, framing_error_flag_q, parity_error_flag_q,
			                                 ctrl_cfg_q[1:0], rx_ninth_bit_q};
			SCM_OFF_DATA:   rd_value[7:0] = rx_buf_q;
			SCM_OFF_STATUS: rd_value[1:0] = {tx_busy, rx_pending_flag_q};
			default:        rd_value = 32'h0000_0000;
		endcase
	end

	// Bus answer flops.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
		else if (psel && penable && !pready_q)
		begin
			pready_q  <= 1'b1;
			pslverr_q <= !mapped;
			prdata_q  <= pwrite ? 32'h0000_0000 : rd_value;
		end
		else
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// Software-written configuration.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			channel_mode_reg_q <= SCM_MODE_RST;
			ctrl_cfg_q         <= SCM_CTRL_RST;
		end
		else if (wr_done && (paddr == SCM_OFF_MODE))
		begin
			channel_mode_reg_q <= pwdata[5:0];
		end
		else if (wr_done && (paddr == SCM_OFF_CTRL))
		begin
			ctrl_cfg_q <= {1'b0, pwdata[SCM_CTRL_EVEN_BIT], pwdata[SCM_CTRL_PE_BIT]};
		end
	end

	// ------------------------------------------------------------
	// Transmitter.
	// ------------------------------------------------------------

	// A buffer write while a frame is in flight is dropped; software watches the busy bit.
	assign tx_load  = wr_done && (paddr == SCM_OFF_DATA) && (mode_sel != SCM_MODE_SHIFT);
	assign tx_nbits = frame_bits;

	// Payload with unused top bits forced high so they merge into the stop bit.
	always_comb
	begin
		tx_payload = 9'h1FF;
		unique case (mode_sel)
			SCM_MODE_7BIT:  tx_payload = {2'b11, pwdata[6:0]};
			SCM_MODE_8BIT:  tx_payload = {1'b1, pwdata[7:0]};
			SCM_MODE_9BIT:  tx_payload = {tx_ninth_bit, pwdata[7:0]};
			SCM_MODE_SHIFT: tx_payload = 9'h1FF;
		endcase
		if (parity_on && (mode_sel == SCM_MODE_7BIT))
		begin
			tx_payload[7] = (^pwdata[6:0]) ^ !parity_even;
		end
		if (parity_on && (mode_sel == SCM_MODE_8BIT))
		begin
			tx_payload[8] = (^pwdata[7:0]) ^ !parity_even;
		end
	end

	scm_tx u_tx
	(
		.clock     (clock),
		.rst_n     (rst_n),
		.baud_tick (baud_tick),
		.load      (tx_load),
		.payload   (tx_payload),
		.nbits     (tx_nbits),
		.busy      (tx_busy),
		.txd       (serial_out_pin)
	);

	// ------------------------------------------------------------
	// Asynchronous receiver.
	// ------------------------------------------------------------
	assign maj        = maj3(rx_samp_q[1], rx_samp_q[0], rx_in);
	assign async_done = (rx_state_q == SCM_RX_STOP) && baud_tick && (rx_tick_q == SCM_SAMPLE_C);

	// Every bit is judged by three samples, so a single glitch cannot flip it.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_state_q <= SCM_RX_IDLE;
			rx_tick_q  <= 4'h0;
			rx_idx_q   <= 4'h0;
			rx_samp_q  <= 2'h3;
			rx_bits_q  <= 9'h000;
		end
		else if (baud_tick)
		begin
			rx_tick_q <= rx_tick_q + 4'h1;
			if ((rx_tick_q == SCM_SAMPLE_A) || (rx_tick_q == SCM_SAMPLE_B))
			begin
				rx_samp_q <= {rx_samp_q[0], rx_in};
			end
			unique case (rx_state_q)
				SCM_RX_IDLE:
				begin
					rx_tick_q <= 4'h0;
					if (!rx_in && rx_enable && (mode_sel != SCM_MODE_SHIFT))
					begin
						rx_state_q <= SCM_RX_START;
						rx_bits_q  <= 9'h000;
					end
				end
				SCM_RX_START:
				begin
					if ((rx_tick_q == SCM_SAMPLE_C) && maj)
					begin
						rx_state_q <= SCM_RX_IDLE;
					end
					else if (rx_tick_q == SCM_TICK_LAST)
					begin
						rx_state_q <= SCM_RX_BITS;
						rx_idx_q   <= 4'h0;
					end
				end
				SCM_RX_BITS:
				begin
					if (rx_tick_q == SCM_SAMPLE_C)
					begin
						rx_bits_q[rx_idx_q] <= maj;
					end
					if (rx_tick_q == SCM_TICK_LAST)
					begin
						if (rx_idx_q == frame_bits - 4'h1)
						begin
							rx_state_q <= SCM_RX_STOP;
						end
						rx_idx_q <= rx_idx_q + 4'h1;
					end
				end
				SCM_RX_STOP:
				begin
					if (rx_tick_q == SCM_SAMPLE_C)
					begin
						rx_state_q <= SCM_RX_IDLE;
					end
				end
			endcase
		end
	end

	// Frame verdicts, valid in the stop-bit centre cycle.
	assign rx_wake_drop = (mode_sel == SCM_MODE_9BIT) && wake_filter_bit && !rx_bits_q[8];
	assign rx_overrun   = async_done && !rx_wake_drop && rx_pending_flag_q;
	assign rx_accept    = (async_done && !rx_wake_drop && !rx_pending_flag_q) || sh_done_q;
	assign rx_par_bad   = parity_on && ((mode_sel == SCM_MODE_7BIT) ?
	                      ((^rx_bits_q[6:0]) ^ !parity_even) != rx_bits_q[7] :
	                      ((^rx_bits_q[7:0]) ^ !parity_even) != rx_bits_q[8]);

	// ------------------------------------------------------------
	// Shift-register receiver.
	// ------------------------------------------------------------
	assign sh_sample = ext_clock ? sclk_rise
	                             : (sh_active_q && !sclk_out_q &&
	                                (sh_half_q == 16'(SHIFT_HALF - 1)));

	// The internal clock runs only while the buffer is free, so no overrun can occur here.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sh_active_q <= 1'b0;
			sh_half_q   <= 16'h0000;
			sclk_out_q  <= 1'b1;
			sh_cnt_q    <= 4'h0;
			sh_bits_q   <= 8'h00;
			sh_done_q   <= 1'b0;
		end
		else
		begin
			sh_done_q <= 1'b0;
			if ((mode_sel != SCM_MODE_SHIFT) || !rx_enable || rx_pending_flag_q)
			begin
				sh_active_q <= 1'b0;
				sclk_out_q  <= 1'b1;
				sh_cnt_q    <= 4'h0;
			end
			else
			begin
				if (!ext_clock && !sh_active_q && !sh_done_q)
				begin
					sh_active_q <= 1'b1;
					sh_half_q   <= 16'h0000;
					sclk_out_q  <= 1'b0;
				end
				else if (sh_active_q)
				begin
					sh_half_q <= sh_half_q + 16'h0001;
					if (sh_half_q == 16'(SHIFT_HALF - 1))
					begin
						sh_half_q  <= 16'h0000;
						sclk_out_q <= !sclk_out_q;
					end
				end
				if (sh_sample)
				begin
					sh_bits_q <= {rx_in, sh_bits_q[7:1]};
					sh_cnt_q  <= sh_cnt_q + 4'h1;
					if (sh_cnt_q == SCM_SHIFT_BITS - 4'h1)
					begin
						sh_done_q   <= 1'b1;
						sh_active_q <= 1'b0;
						sh_cnt_q    <= 4'h0;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Receive buffer, pending flag and interrupt.
	// ------------------------------------------------------------

	// A new word wins over a read in the same cycle, so an accepted word is never lost.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_buf_q          <= SCM_BUF_RST;
			rx_ninth_bit_q    <= 1'b0;
			rx_pending_flag_q <= 1'b0;
			rx_irq_q          <= 1'b0;
		end
		else
		begin
			rx_irq_q <= rx_accept;
			if (rx_accept)
			begin
				rx_pending_flag_q <= 1'b1;
				rx_buf_q          <= sh_done_q ? sh_bits_q : rx_bits_q[7:0];
				if (!sh_done_q && (mode_sel != SCM_MODE_7BIT))
				begin
					rx_ninth_bit_q <= rx_bits_q[8];
				end
			end
			else if (rd_data_done)
			begin
				rx_pending_flag_q <= 1'b0;
			end
		end
	end

	// Error flags clear by writing one; a new error in the same cycle wins.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			parity_error_flag_q  <= 1'b0;
			framing_error_flag_q <= 1'b0;
			overrun_error_flag_q <= 1'b0;
		end
		else
		begin
			if (async_done && !rx_wake_drop && rx_par_bad)
				parity_error_flag_q <= 1'b1;
			else if (wr_done && (paddr == SCM_OFF_CTRL) && pwdata[SCM_CTRL_PARITY_ERROR_FLAG_BIT])
				parity_error_flag_q <= 1'b0;
			if (async_done && !rx_wake_drop && !maj)
				framing_error_flag_q <= 1'b1;
			else if (wr_done && (paddr == SCM_OFF_CTRL) && pwdata[SCM_CTRL_FRAMING_ERROR_FLAG_BIT])
				framing_error_flag_q <= 1'b0;
			if (rx_overrun)
				overrun_error_flag_q <= 1'b1;
			else if (wr_done && (paddr == SCM_OFF_CTRL) && pwdata[SCM_CTRL_OVERRUN_ERROR_FLAG_BIT])
				overrun_error_flag_q <= 1'b0;
		end
	end

	// Shift clock pin drive, only while the internal clock source is selected.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_clock_pin_out <= 1'b1;
			shift_clock_pin_oe  <= 1'b0;
		end
		else
		begin
			shift_clock_pin_out <= sclk_out_q || (mode_sel != SCM_MODE_SHIFT) || ext_clock;
			shift_clock_pin_oe  <= (mode_sel == SCM_MODE_SHIFT) && !ext_clock;
		end
	end

	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign rx_interrupt = rx_irq_q;

endmodule
`default_nettype wire

// *** verification/scm_serial_channel_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module scm_serial_channel_chk
	import scm_pkg::*;
#(
	parameter int SHIFT_HALF = 8
)
(
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pwrite,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       baud_tick,
	input wire logic       serial_out_pin,
	input wire logic       shift_clock_pin_out,
	input wire logic       shift_clock_pin_oe,
	input wire logic       rx_interrupt
);
	// ----------------
	// Helpers
	// ----------------
	logic       wr_dat;
	logic       rd_dat;
	logic [7:0] low_q;
	logic       armed_q;

	// Data-word accesses at the edge that completes them.
	assign wr_dat = psel && pready && pwrite && paddr == SCM_OFF_DATA;
	assign rd_dat = psel && pready && !pwrite && paddr == SCM_OFF_DATA;

	// Length of the current low phase of the driven shift clock.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			low_q <= 8'h00;
		else
			low_q <= shift_clock_pin_out ? 8'h00 : low_q + 8'h01;
	end

	// Set while an announced word waits to be read.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			armed_q <= 1'b0;
		else if (rx_interrupt)
			armed_q <= 1'b1;
		else if (rd_dat)
			armed_q <= 1'b0;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_one_ready;
		pready ##1 !pready;
	endsequence

	AST_PREADY_ONE: assert property (s_access |=> s_one_ready)
		else $error("pready not one cycle");
	AST_SLVERR: assert property (pready && paddr > SCM_OFF_STATUS |-> pslverr)
		else $error("unmapped without pslverr");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_IRQ_PULSE: assert property (rx_interrupt |=> !rx_interrupt)
		else $error("interrupt too long");
	AST_IRQ_READ: assert property (rx_interrupt |-> !armed_q)
		else $error("interrupt before read");
	AST_TX_STEP: assert property ($changed(serial_out_pin) |-> $past(baud_tick) || $past(wr_dat) || $past(wr_dat, 2))
		else $error("line moved off tick");
	AST_SCLK_IDLE: assert property (!shift_clock_pin_oe |-> shift_clock_pin_out)
		else $error("undriven clock not high");
	AST_SCLK_HALF: assert property ($rose(shift_clock_pin_out) && shift_clock_pin_oe |-> $past(low_q) == SHIFT_HALF - 1)
		else $error("low phase length");
endmodule

bind scm_serial_channel scm_serial_channel_chk #(.SHIFT_HALF(SHIFT_HALF)) i_scm_serial_channel_chk
(
	.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .baud_tick(baud_tick), .serial_out_pin(serial_out_pin),
	.shift_clock_pin_out(shift_clock_pin_out), .shift_clock_pin_oe(shift_clock_pin_oe),
	.rx_interrupt(rx_interrupt)
);

`default_nettype wire

// *** verification/scm_peer.sv ***
`timescale 1ns/1ps
`default_nettype none

module scm_peer
(
	input  wire logic clock,
	input  wire logic baud_tick,
	input  wire logic txd,
	input  wire logic sclk,
	output var logic  line
);
	// ----------------
	// Far-side port and shift register
	// ----------------
	logic [9:0] got;
	logic [7:0] shreg;
	logic       shift_on;

	// The line idles high.
	initial
	begin
		line = 1'b1;
		shift_on = 1'b0;
	end

	// Waits n ticks of the shared baud generator.
	task automatic ticks(input int n);
		repeat (n)
			do
				@(posedge clock);
			while (baud_tick !== 1'b1);
	endtask

	// Start low, n bits LSB first, chosen stop level, then idle.
	task automatic send(input logic [8:0] b, input int n, input logic stop);
		shift_on = 1'b0;
		line <= 1'b0;
		ticks(16);
		for (int i = 0; i < n; i++)
		begin
			line <= b[i];
			ticks(16);
		end
		line <= stop;
		ticks(16);
		line <= 1'b1;
		ticks(16);
	endtask

	// Each falling clock presents the next bit, so data is steady at the rise.
	task automatic load(input logic [7:0] v);
		shreg <= v;
		line <= v[0];
		shift_on <= 1'b1;
	endtask

	// Shift register output stage.
	always @(negedge sclk)
	begin
		if (shift_on)
		begin
			line <= shreg[0];
			shreg <= {1'b1, shreg[7:1]};
		end
	end

	// Ten bit-centre samples of every frame the device sends.
	initial
	forever
	begin
		@(negedge txd);
		ticks(8);
		repeat (10)
		begin
			ticks(16);
			got <= {txd, got[9:1]};
		end
	end
endmodule

`default_nettype wire

// *** verification/scm_serial_channel_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

module scm_serial_channel_tb;
	import scm_pkg::*;
	// ----------------
	// Bench
	// ----------------
	localparam logic [7:0] MD = SCM_OFF_MODE;
	localparam logic [7:0] CT = SCM_OFF_CTRL;
	localparam logic [7:0] DT = SCM_OFF_DATA;
	localparam logic [7:0] ST = SCM_OFF_STATUS;
	logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, err, got;
	logic        baud_tick, rxd, txd, sclk_in, sclk_out, sclk_oe, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          failures, compares;

	scm_serial_channel #(.SHIFT_HALF(4)) i_scm_serial_channel
	(
		.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .baud_tick(baud_tick),
		.serial_in_pin(rxd), .serial_out_pin(txd), .shift_clock_pin_in(sclk_in),
		.shift_clock_pin_out(sclk_out), .shift_clock_pin_oe(sclk_oe), .rx_interrupt(irq)
	);
	scm_peer i_scm_peer
	(
		.clock(clock), .baud_tick(baud_tick), .txd(txd), .sclk(sclk_oe ? sclk_out : sclk_in), .line(rxd)
	);

	// 200 MHz clock; a baud tick every other cycle keeps frames short.
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock)
		baud_tick <= ~baud_tick;

	// One APB transfer; holds everything until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK(rd, x)
	endtask

	// Notes whether an interrupt pulse showed within lim cycles.
	task automatic wait_irq(input int lim);
		got = 1'b0;
		repeat (lim)
		begin
			@(posedge clock);
			if (irq === 1'b1)
				got = 1'b1;
		end
	endtask

	task automatic frame(input logic [31:0] m, input logic [31:0] c, input logic [8:0] b, input int n,
		input logic stop, input logic xi);
		apb(1'b1, CT, c | 32'h0000_0038);
		apb(1'b1, MD, m);
		fork
			i_scm_peer.send(b, n, stop);
			wait_irq(600);
		join
		`CHK(got, xi)
	endtask

	task automatic t_regs;
		for (int a = 0; a < 16; a += 4)
			chk_rd(a[7:0], 32'h0);
		apb(1'b1, MD, 32'hFFFF_FFFF);
		chk_rd(MD, 32'h3F);
		apb(1'b1, MD, 32'h0);
		apb(1'b1, CT, 32'hFFFF_FFFF);
		chk_rd(CT, 32'h06);
		apb(1'b1, ST, 32'h3);
		chk_rd(ST, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		`CHK({err, rd}, 33'h1_0000_0000)
		$display("t_regs done");
	endtask

	task automatic t_async;
		frame(32'h03, 32'h0, 9'h055, 7, 1'b1, 1'b1);
		chk_rd(CT, 32'h00);
		chk_rd(DT, 32'h55);
		frame(32'h05, 32'h0, 9'h03C, 8, 1'b0, 1'b1);
		chk_rd(CT, 32'h10);
		chk_rd(DT, 32'h3C);
		frame(32'h03, 32'h6, 9'h0A3, 8, 1'b1, 1'b1);
		chk_rd(CT, 32'h06);
		chk_rd(DT, 32'hA3);
		frame(32'h05, 32'h2, 9'h1C3, 9, 1'b1, 1'b1);
		chk_rd(CT, 32'h03);
		chk_rd(DT, 32'hC3);
		frame(32'h05, 32'h6, 9'h001, 9, 1'b1, 1'b1);
		chk_rd(CT, 32'h0E);
		chk_rd(DT, 32'h01);
		frame(32'h07, 32'h6, 9'h1A5, 9, 1'b1, 1'b1);
		chk_rd(CT, 32'h07);
		chk_rd(DT, 32'hA5);
		chk_rd(ST, 32'h0);
		$display("t_async done");
	endtask

	task automatic t_wake;
		frame(32'h0F, 32'h0, 9'h042, 9, 1'b1, 1'b0);
		chk_rd(ST, 32'h0);
		frame(32'h0F, 32'h0, 9'h107, 9, 1'b1, 1'b1);
		chk_rd(CT, 32'h01);
		chk_rd(DT, 32'h07);
		frame(32'h07, 32'h0, 9'h099, 9, 1'b1, 1'b1);
		chk_rd(CT, 32'h00);
		chk_rd(DT, 32'h99);
		frame(32'h05, 32'h0, 9'h011, 8, 1'b1, 1'b1);
		frame(32'h05, 32'h0, 9'h022, 8, 1'b1, 1'b0);
		chk_rd(CT, 32'h20);
		chk_rd(DT, 32'h11);
		$display("t_wake done");
	endtask

	task automatic t_tx;
		apb(1'b1, MD, 32'h17);
		apb(1'b1, DT, 32'h5A);
		chk_rd(ST, 32'h2);
		repeat (500) @(posedge clock);
		`CHK(i_scm_peer.got, 10'h35A)
		apb(1'b1, CT, 32'h0000_0002);
		apb(1'b1, MD, 32'h03);
		apb(1'b1, DT, 32'h35);
		repeat (500) @(posedge clock);
		`CHK(i_scm_peer.got, 10'h3B5)
		$display("t_tx done");
	endtask

	task automatic t_shift;
		apb(1'b1, MD, 32'h00);
		i_scm_peer.load(8'hB4);
		wait_irq(100);
		`CHK(got, 1'b0)
		apb(1'b1, MD, 32'h01);
		wait_irq(100);
		`CHK(got, 1'b1)
		chk_rd(ST, 32'h1);
		i_scm_peer.load(8'h3C);
		chk_rd(DT, 32'hB4);
		wait_irq(100);
		`CHK(got, 1'b1)
		apb(1'b1, MD, 32'h21);
		chk_rd(DT, 32'h3C);
		i_scm_peer.load(8'h69);
		repeat (8)
		begin
			#32 sclk_in = 1'b0;
			#32 sclk_in = 1'b1;
		end
		wait_irq(20);
		`CHK(got, 1'b1)
		chk_rd(DT, 32'h69);
		$display("t_shift done");
	endtask

	task automatic give_verdict;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Reset for 12 cycles, then the scenarios.
	initial
	begin
		failures = 0;
		compares = 0;
		rst_n = 1'b0;
		baud_tick = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sclk_in = 1'b1;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		t_regs();
		t_async();
		t_wake();
		t_tx();
		t_shift();
		give_verdict();
	end

	// A hang ends the run as a failure.
	initial
	begin
		#200000;
		failures++;
		give_verdict();
	end
endmodule

`default_nettype wire
